// ### hw/fsc_flash_regs.sv
`timescale 1ns/1ps
module fsc_flash_regs #(
    parameter int WRITE_CYCLES = fsc_pkg::REG_WRITE_CYCLES,
    parameter int NUM_LOCKS = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire fsc_pkg::fsc_pins_s pins,
    input wire logic array_op_busy,
    input wire logic array_op_done,
    input wire logic array_op_fail,
    input wire logic suspended,
    output logic serial_out,
    output logic serial_out_oe,
    output logic write_permit_latch,
    output logic write_busy_flag,
    output fsc_pkg::fsc_setup_s setup,
    output logic [7:0] drive_strength_pct,
    output logic [3:0] dual_dummy_clocks,
    output logic [3:0] quad_dummy_clocks,
    output logic [4:0] block_protect_field,
    output logic protect_complement,
    output logic quad_io_enable,
    output logic regs_locked,
    output logic pause_active,
    output logic pin_reset_active,
    output logic [NUM_LOCKS-1:0] block_lock
);
    import fsc_pkg::*;

    localparam int CW = $clog2(WRITE_CYCLES + 1);

    if (WRITE_CYCLES < 1 || NUM_LOCKS < 1) begin : g_bad_params
        $error("fsc_flash_regs: counts must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    fsc_pins_s pins_meta;
    fsc_pins_s pins_sync;
    fsc_pins_s pins_last;
    fsc_frame_e frame;
    fsc_frame_e next_frame;
    logic [2:0] bit_count;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic [15:0] data_in;
    logic [4:0] data_count;
    logic [7:0] out_shift;
    logic [2:0] out_count;
    logic out_drive;
    logic [15:0] state_store;
    logic [7:0] setup_reg;
    logic reg_cycle_active;
    logic [CW-1:0] cycle_count;
    logic selected;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cycle_done;
    logic write_ok;
    logic permit_set;
    logic permit_clear;
    logic may_write;
    logic may_permit;
    logic [15:0] state_view;
    logic [15:0] state_new;
    logic [7:0] read_byte;

    ////////////////////////////////////////////////////////////////////////
    // Picks the frame phase that follows a complete opcode.
    function automatic fsc_frame_e fsc_route(input logic [7:0] op,
                                             input logic wr_ok,
                                             input logic pm_ok);
        if (op == CMD_READ_SETUP || op == CMD_READ_STATE_LO ||
            op == CMD_READ_STATE_HI) begin
            return FR_SEND;
        end else if (op == CMD_WRITE_STATE || op == CMD_WRITE_STATE_HI ||
                     op == CMD_WRITE_SETUP) begin
            return wr_ok ? FR_TAKE : FR_SKIP;
        end else if (op == CMD_WRITE_PERMIT || op == CMD_WRITE_FORBID) begin
            return pm_ok ? FR_TAKE : FR_SKIP;
        end
        return FR_SKIP;
    endfunction

    // Selects the byte that a read command returns.
    function automatic logic [7:0] fsc_read_byte(input logic [7:0] op,
                                                 input logic [15:0] st,
                                                 input logic [7:0] su);
        if (op == CMD_READ_SETUP) begin
            return su;
        end else if (op == CMD_READ_STATE_HI) begin
            return st[15:8];
        end
        return st[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Two flip-flops on every pin, then a third stage for edge finding.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pins_meta <= PINS_IDLE;
            pins_sync <= PINS_IDLE;
            pins_last <= PINS_IDLE;
        end else begin
            pins_meta <= pins;
            pins_sync <= pins_meta;
            pins_last <= pins_sync;
        end
    end

    // Edges of the serial clock, gated by the pause pin, and of chip select, which is not gated.
    always_comb begin
        selected = ~pins_sync.chip_sel_n;
        sclk_rise = pins_sync.serial_clk & ~pins_last.serial_clk
                    & ~pause_active;
        sclk_fall = ~pins_sync.serial_clk & pins_last.serial_clk
                    & ~pause_active;
        cs_rise = pins_sync.chip_sel_n & ~pins_last.chip_sel_n;
    end

    // The shared pin acts only while quad mode is off.
    always_comb begin
        pause_active = selected & ~quad_io_enable & ~setup.pin_is_reset
                       & ~pins_sync.pause_reset_n;
        pin_reset_active = ~quad_io_enable & setup.pin_is_reset
                           & ~pins_sync.pause_reset_n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection, permission and the live state register view.
    always_comb begin
        regs_locked = state_store[ST_PROT_HIGH_BIT]
                      | (state_store[ST_PROT_LOW_BIT] & ~quad_io_enable
                         & ~pins_sync.write_protect_n);
        write_busy_flag = reg_cycle_active | array_op_busy;
        may_write = write_permit_latch & ~write_busy_flag
                    & ~regs_locked;
        may_permit = ~write_busy_flag;
        next_opcode = {opcode[6:0], pins_sync.serial_in};
        next_frame = fsc_route(next_opcode, may_write, may_permit);
        state_view = state_store;
        state_view[ST_BUSY_BIT] = write_busy_flag;
        state_view[ST_PERMIT_BIT] = write_permit_latch;
        state_view[ST_FAIL_BIT] = array_op_fail;
        state_view[ST_SUSPEND_BIT] = suspended;
        read_byte = fsc_read_byte(opcode, state_view, setup_reg);
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer: opcode, then data in, data out or ignore.
    always_ff @(posedge clock) begin
        if (sys_rst || pin_reset_active || !selected) begin
            frame <= FR_IDLE;
            bit_count <= 3'h0;
            opcode <= 8'h00;
            data_in <= 16'h0000;
            data_count <= 5'h00;
        end else begin
            unique case (frame)
                FR_IDLE: begin
                    frame <= FR_OPCODE;
                end
                FR_OPCODE: begin
                    if (sclk_rise) begin
                        opcode <= next_opcode;
                        bit_count <= bit_count + 3'h1;
                        if (bit_count == 3'h7) begin
                            frame <= next_frame;
                        end
                    end
                end
                FR_TAKE: begin
                    if (sclk_rise) begin
                        data_in <= {data_in[14:0], pins_sync.serial_in};
                        if (data_count != 5'h11) begin
                            data_count <= data_count + 5'h01;
                        end
                    end
                end
                FR_SEND, FR_SKIP: begin
                    frame <= frame;
                end
            endcase
        end
    end

    // Read data leaves on falling edges, most significant bit first.
    always_ff @(posedge clock) begin
        if (sys_rst || frame != FR_SEND) begin
            out_shift <= 8'h00;
            out_count <= 3'h0;
            out_drive <= 1'b0;
            serial_out <= 1'b0;
        end else if (sclk_fall) begin
            out_drive <= 1'b1;
            out_count <= out_count + 3'h1;
            if (out_count == 3'h0) begin
                // Each byte is fetched fresh, so polling sees live state.
                serial_out <= read_byte[7];
                out_shift <= {read_byte[6:0], 1'b0};
            end else begin
                serial_out <= out_shift[7];
                out_shift <= {out_shift[6:0], 1'b0};
            end
        end
    end

    // Only the serial output is driven; other data lines are not read.
    assign serial_out_oe = out_drive & ~pause_active;

    ////////////////////////////////////////////////////////////////////////
    // Commit checks made at the rise of chip select.
    always_comb begin
        write_ok = 1'b0;
        if (cs_rise && frame == FR_TAKE) begin
            if (opcode == CMD_WRITE_STATE) begin
                write_ok = (data_count == 5'h08)
                           || (data_count == 5'h10);
            end else if (opcode == CMD_WRITE_STATE_HI ||
                         opcode == CMD_WRITE_SETUP) begin
                write_ok = (data_count == 5'h08);
            end
        end
        permit_set = cs_rise && frame == FR_TAKE && data_count == 5'h00
                     && opcode == CMD_WRITE_PERMIT;
        permit_clear = cs_rise && frame == FR_TAKE && data_count == 5'h00
                       && opcode == CMD_WRITE_FORBID;
    end

    // New state value; a lone byte for the low command keeps the top.
    always_comb begin
        state_new = state_store;
        if (opcode == CMD_WRITE_STATE && data_count == 5'h10) begin
            state_new = {data_in[7:0], data_in[15:8]};
        end else if (opcode == CMD_WRITE_STATE) begin
            state_new = {state_store[15:8], data_in[7:0]};
        end else begin
            state_new = {data_in[7:0], state_store[7:0]};
        end
        state_new = (state_store & ST_KEEP_MASK)
                    | (state_new & ~ST_KEEP_MASK)
                    | (state_store & ST_OTP_MASK);
    end

    // Register storage; the setup register drops reserved bits.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_store <= ST_RESET;
            setup_reg <= SU_RESET;
        end else if (pin_reset_active) begin
            setup_reg[SU_DUMMY_BIT] <= 1'b0;
        end else if (write_ok && opcode == CMD_WRITE_SETUP) begin
            setup_reg <= data_in[7:0] & SU_WRITABLE_MASK;
        end else if (write_ok) begin
            state_store <= state_new & ~ST_KEEP_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Self-timed register write cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_cycle_active <= 1'b0;
            cycle_count <= '0;
        end else if (write_ok) begin
            reg_cycle_active <= 1'b1;
            cycle_count <= CW'(WRITE_CYCLES - 1);
        end else if (reg_cycle_active) begin
            cycle_count <= cycle_count - CW'(1);
            if (cycle_count == '0) begin
                reg_cycle_active <= 1'b0;
            end
        end
    end

    assign cycle_done = reg_cycle_active && cycle_count == '0;

    // Permit latch: a set in the same cycle as a clear wins.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            write_permit_latch <= 1'b0;
        end else if (permit_set) begin
            write_permit_latch <= 1'b1;
        end else if (cycle_done || array_op_done || permit_clear ||
                     pin_reset_active) begin
            write_permit_latch <= 1'b0;
        end
    end

    // Individual block locks come up set after any reset.
    always_ff @(posedge clock) begin
        if (sys_rst || pin_reset_active) begin
            block_lock <= {NUM_LOCKS{BLOCK_LOCK_RESET}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded setup outputs, drive strength and dummy clocks, all from flip-flops.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            drive_strength_pct <= DRV_PCT_00;
            dual_dummy_clocks <= DUAL_DUMMY_SHORT;
            quad_dummy_clocks <= QUAD_DUMMY_SHORT;
        end else begin
            unique case (setup_reg[SU_DRIVE_LSB+:2])
                2'b00: drive_strength_pct <= DRV_PCT_00;
                2'b01: drive_strength_pct <= DRV_PCT_01;
                2'b10: drive_strength_pct <= DRV_PCT_10;
                2'b11: drive_strength_pct <= DRV_PCT_11;
            endcase
            dual_dummy_clocks <= setup_reg[SU_DUMMY_BIT] ?
                DUAL_DUMMY_LONG : DUAL_DUMMY_SHORT;
            quad_dummy_clocks <= setup_reg[SU_DUMMY_BIT] ?
                QUAD_DUMMY_LONG : QUAD_DUMMY_SHORT;
        end
    end

    // Plain views of the stored fields.
    assign setup = '{pin_is_reset: setup_reg[SU_PIN_SEL_BIT],
                     drive_level_field: setup_reg[SU_DRIVE_LSB+:2],
                     protect_scheme_select: setup_reg[SU_SCHEME_BIT],
                     dummy_length_select: setup_reg[SU_DUMMY_BIT]};
    assign block_protect_field = state_store[ST_BP_LSB+:5];
    assign protect_complement = state_store[ST_CMP_BIT];
    assign quad_io_enable = state_store[ST_QUAD_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Checks and coverage.
    int cycle_age;

    // Counts cycles of the running write cycle.
    always_ff @(posedge clock) begin
        if (sys_rst || !reg_cycle_active) begin
            cycle_age <= 0;
        end else begin
            cycle_age <= cycle_age + 1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    busy_on_commit_a: assert property (write_ok |=> write_busy_flag)
        else $error("busy flag not raised after accepted write");
    cycle_length_a: assert property (cycle_done |->
        cycle_age == WRITE_CYCLES - 1)
        else $error("register write cycle has wrong length");
    latch_cleared_a: assert property ((cycle_done && !permit_set)
        |=> !write_permit_latch && !reg_cycle_active)
        else $error("permit latch still set after write cycle");
    setup_cause_a: assert property ($changed(setup_reg) |->
        $past(write_ok && opcode == CMD_WRITE_SETUP) ||
        $past(pin_reset_active))
        else $error("setup register changed without a valid write");
    state_cause_a: assert property ($changed(state_store) |->
        $past(write_ok) && $past(write_permit_latch))
        else $error("state register changed without a permitted write");
    reserved_zero_a: assert property (
        (setup_reg & ~SU_WRITABLE_MASK) == 8'h00)
        else $error("reserved setup bits not zero");
    high_kept_a: assert property ((write_ok && opcode == CMD_WRITE_STATE
        && data_count == 5'h08) |=> $stable(state_store[15:8]))
        else $error("one byte state write changed the high byte");
    refuse_locked_a: assert property ((frame == FR_OPCODE && sclk_rise
        && bit_count == 3'h7 && next_opcode == CMD_WRITE_STATE
        && regs_locked) |=> frame == FR_SKIP)
        else $error("state write accepted while protected");
    quad_pin_a: assert property (quad_io_enable |->
        !pause_active && !pin_reset_active)
        else $error("pause or reset acts with quad mode on");
    drive_low_a: assert property ((setup.drive_level_field == 2'b11)
        [*2] |-> drive_strength_pct == DRV_PCT_11)
        else $error("drive strength wrong for code 11");
    locks_after_reset_a: assert property ($fell(pin_reset_active) |->
        &block_lock)
        else $error("block locks not set after reset");

    cover property (write_ok && opcode == CMD_WRITE_STATE
        && data_count == 5'h10);
    cover property (write_ok && opcode == CMD_WRITE_SETUP);
    cover property (frame == FR_SEND && opcode == CMD_READ_SETUP
        && reg_cycle_active && sclk_fall);
    cover property (cs_rise && frame == FR_TAKE && !write_ok
        && opcode == CMD_WRITE_SETUP);

endmodule

// ### hw/fsc_pkg.sv
package fsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command codes, shifted in most significant bit first.
    localparam logic [7:0] CMD_WRITE_STATE = 8'h01;
    localparam logic [7:0] CMD_WRITE_STATE_HI = 8'h31;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h11;
    localparam logic [7:0] CMD_READ_SETUP = 8'h15;
    localparam logic [7:0] CMD_READ_STATE_LO = 8'h05;
    localparam logic [7:0] CMD_READ_STATE_HI = 8'h35;
    localparam logic [7:0] CMD_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] CMD_WRITE_FORBID = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // State register layout (sixteen bits).
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PERMIT_BIT = 1;
    localparam int ST_PROT_LOW_BIT = 7;
    localparam int ST_PROT_HIGH_BIT = 8;
    localparam int ST_QUAD_BIT = 9;
    localparam int ST_FAIL_BIT = 10;
    localparam int ST_CMP_BIT = 14;
    localparam int ST_SUSPEND_BIT = 15;
    localparam int ST_BP_LSB = 2;
    localparam logic [15:0] ST_KEEP_MASK = 16'h8403;
    localparam logic [15:0] ST_OTP_MASK = 16'h3800;
    localparam logic [15:0] ST_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Setup register layout (eight bits).
    localparam int SU_PIN_SEL_BIT = 7;
    localparam int SU_DRIVE_LSB = 5;
    localparam int SU_SCHEME_BIT = 2;
    localparam int SU_DUMMY_BIT = 1;
    localparam logic [7:0] SU_WRITABLE_MASK = 8'hE6;
    localparam logic [7:0] SU_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Drive strength in percent and dummy clock counts.
    localparam logic [7:0] DRV_PCT_00 = 8'h3C;
    localparam logic [7:0] DRV_PCT_01 = 8'h64;
    localparam logic [7:0] DRV_PCT_10 = 8'h8C;
    localparam logic [7:0] DRV_PCT_11 = 8'h28;
    localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
    localparam logic [3:0] DUAL_DUMMY_LONG = 4'h8;
    localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
    localparam logic [3:0] QUAD_DUMMY_LONG = 4'hA;
    localparam logic BLOCK_LOCK_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Register write time and its cycle count at the 4 ns clock.
    localparam int CLK_PERIOD_NS = 4;
    localparam int REG_WRITE_TIME_US = 2000;
    localparam int REG_WRITE_CYCLES = REG_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Pin group and decoded setup fields.
    typedef struct packed {
        logic chip_sel_n;
        logic serial_clk;
        logic serial_in;
        logic write_protect_n;
        logic pause_reset_n;
    } fsc_pins_s;

    localparam fsc_pins_s PINS_IDLE = 5'b10011;

    typedef struct packed {
        logic pin_is_reset;
        logic [1:0] drive_level_field;
        logic protect_scheme_select;
        logic dummy_length_select;
    } fsc_setup_s;

    typedef enum logic [4:0] {
        FR_IDLE = 5'b00001,
        FR_OPCODE = 5'b00010,
        FR_TAKE = 5'b00100,
        FR_SEND = 5'b01000,
        FR_SKIP = 5'b10000
    } fsc_frame_e;

endpackage

// ### verification/fsc_spi_host.sv
`timescale 1ns/1ps
// Host side of the serial link; its clock stands low between frames.
module fsc_spi_host (
    input wire logic clock,
    input wire logic serial_out,
    output logic chip_sel_n,
    output logic serial_clk,
    output logic serial_in
);
    // Idle levels from time zero.
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // Shifts nbits of tx out msb first and collects serial_out.
    task automatic xfer(input logic [31:0] tx, input int nbits,
                        output logic [31:0] rx);
        rx = '0;
        @(posedge clock);
        #1 chip_sel_n = 1'b0;
        repeat (4) @(posedge clock);
        for (int i = nbits - 1; i >= 0; i--) begin
            #1 serial_in = tx[i];
            repeat (10) @(posedge clock);
            #1 serial_clk = 1'b1;
            rx = {rx[30:0], serial_out};
            repeat (10) @(posedge clock);
            #1 serial_clk = 1'b0;
        end
        repeat (2) @(posedge clock);
        #1 chip_sel_n = 1'b1;
        serial_in = ~serial_in;
        repeat (4) @(posedge clock);
    endtask
endmodule

// ### verification/tb_flash_status_config_register_access.sv
`timescale 1ns/1ps
// Drives the register block through the host model and judges the replies.
module tb_flash_status_config_register_access;
    import fsc_pkg::*;
    localparam int WCYC = 400;
    logic clock, sys_rst, wp_n, pr_n, cs_n, sclk, mosi, so, pm, busy;
    logic [31:0] rx;
    fsc_setup_s su;
    logic [7:0] pct;
    logic [3:0] dd, qd;
    logic [4:0] bp;
    logic cmp, locked, pause, prst, qe;
    logic [15:0] locks;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    fsc_flash_regs #(.WRITE_CYCLES(WCYC), .NUM_LOCKS(16)) dut (
        .clock(clock), .sys_rst(sys_rst),
        .pins({cs_n, sclk, mosi, wp_n, pr_n}),
        .array_op_busy(1'b0), .array_op_done(1'b0),
        .array_op_fail(1'b0), .suspended(1'b0),
        .serial_out(so), .serial_out_oe(), .write_permit_latch(pm),
        .write_busy_flag(busy), .setup(su), .drive_strength_pct(pct),
        .dual_dummy_clocks(dd), .quad_dummy_clocks(qd),
        .block_protect_field(bp), .protect_complement(cmp),
        .quad_io_enable(qe), .regs_locked(locked), .pause_active(pause),
        .pin_reset_active(prst), .block_lock(locks));
    fsc_spi_host host (.clock(clock), .serial_out(so),
        .chip_sel_n(cs_n), .serial_clk(sclk), .serial_in(mosi));

    ////////////////////////////////////////////////////////////////////////
    // Clock generation and the hang limit.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, exp, input string m);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] d,
                       input int nd);
        host.xfer(({24'h0, op} << nd) | {8'h0, d}, 8 + nd, rx);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < WCYC + 50 && busy !== 1'b0; i++)
            @(posedge clock);
        check(busy, 1'b0, "busy stuck");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios, each judged before it returns.
    task automatic t_reset();
        check(su, 5'h00, "setup reset");
        check({pct, dd, qd}, {8'h3C, 4'h4, 4'h6}, "defaults");
        check(locks, 16'hFFFF, "locks");
        cmd(CMD_WRITE_SETUP, 24'hFF, 8);
        check({su, busy}, 6'h00, "write without permit");
        $display("test reset done");
    endtask
    task automatic t_setup();
        cmd(CMD_WRITE_PERMIT, 24'h0, 0);
        check(pm, 1'b1, "permit");
        cmd(CMD_WRITE_SETUP, 24'hFF, 8);
        check(busy, 1'b1, "setup busy");
        cmd(CMD_READ_SETUP, 24'h0, 8);
        check(rx[7:0], 8'hE6, "read setup");
        check({pct, dd, qd}, {8'h28, 4'h8, 4'hA}, "fields");
        check(su, 5'h1F, "setup fields");
        wait_idle();
        check(pm, 1'b0, "permit cleared");
        cmd(CMD_WRITE_PERMIT, 24'h0, 0);
        cmd(CMD_WRITE_SETUP, 24'h0, 9);
        check({su, busy}, 6'h3E, "nine bits");
        $display("test setup done");
    endtask
    task automatic t_state();
        cmd(CMD_WRITE_STATE, 24'h7FC4, 16);
        wait_idle();
        cmd(CMD_READ_STATE_LO, 24'h0, 8);
        check(rx[7:0], 8'h7C, "state low");
        cmd(CMD_READ_STATE_HI, 24'h0, 8);
        check(rx[7:0], 8'h40, "state high");
        cmd(CMD_WRITE_PERMIT, 24'h0, 0);
        cmd(CMD_WRITE_STATE, 24'h04, 8);
        wait_idle();
        check({cmp, bp, pm}, 7'h42, "one byte");
        cmd(CMD_WRITE_PERMIT, 24'h0, 0);
        cmd(CMD_WRITE_STATE_HI, 24'h00, 8);
        wait_idle();
        check({cmp, qe, bp}, 7'h01, "high byte write");
        $display("test state done");
    endtask
    task automatic t_pins();
        @(posedge clock);
        #1 pr_n = 1'b0;
        repeat (6) @(posedge clock);
        check({prst, pause, locks}, 18'h2FFFF, "reset pin");
        #1 pr_n = 1'b1;
        repeat (6) @(posedge clock);
        cmd(CMD_WRITE_PERMIT, 24'h0, 0);
        cmd(CMD_WRITE_STATE, 24'h80, 8);
        wait_idle();
        #1 wp_n = 1'b0;
        repeat (6) @(posedge clock);
        check(locked, 1'b1, "locked");
        cmd(CMD_WRITE_PERMIT, 24'h0, 0);
        cmd(CMD_WRITE_SETUP, 24'h0, 8);
        check({su[4:1], busy}, 5'h1E, "locked write");
        $display("test pins done");
    endtask

    // Reset, then the scenarios in order.
    initial begin
        {sys_rst, wp_n, pr_n} = 3'b111;
        repeat (10) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge clock);
        t_reset();
        t_setup();
        t_state();
        t_pins();
        results();
    end
endmodule
